// ==== rtl/ext_bus_pkg.sv ====
// Shared constants and types for the external parallel bus control ends.
// Assumes one 200 MHz clock on both ends and pins synchronous to it.
package ext_bus_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 64;
    localparam int SEL_W = 4;
    // Bank 0 select bit position
    localparam int BANK0_SEL = 0;
    // Page size field: page is 2**(PAGE_SHIFT_BASE + code) words
    localparam int PAGE_CODE_W = 3;
    localparam logic [4:0] PAGE_SHIFT_BASE = 5'h08;
    localparam logic [PAGE_CODE_W-1:0] PAGE_CODE_RST = 3'h0;
    localparam int MEM_DEPTH = 256;
    localparam int MEM_AW = 8;
    // Wait states the device inserts on a synchronous slave access
    localparam logic [3:0] SLAVE_WAIT_CYC = 4'h2;
    typedef enum logic [1:0] {BUS_OWN, BUS_HANDOFF, BUS_GRANTED} bus_state_type;
endpackage

// ==== rtl/ext_bus_if.sv ====
// Pin-level carrier between the device end and the far (host) end.
// Three-state lines carry drive, value and active-low output enable per end.
`timescale 1ns/1ps
interface ext_bus_if;
    import ext_bus_pkg::*;
    logic [ADDR_W-1:0] dev_addr;
    logic [DATA_W-1:0] dev_data;
    logic [SEL_W-1:0] dev_sel_n;
    logic dev_read_strobe_n;
    logic dev_write_strobe_n;
    logic dev_burst_seq;
    logic dev_bus_oe_n;
    logic page;
    logic page_oe_n;
    logic dev_ack;
    logic dev_ack_oe_n;
    logic host_bus_grant_n;
    logic [ADDR_W-1:0] host_addr;
    logic [DATA_W-1:0] host_wdata;
    logic host_read_strobe_n;
    logic host_write_strobe_n;
    logic host_burst_seq;
    logic host_bus_oe_n;
    logic host_bus_req_n;
    logic bus_suspend_n;
    logic ext_ack;
    logic [DATA_W-1:0] dev_rdata;
    logic dev_rdata_oe_n;
    logic [5:0] mp_bus_req_n;
    modport dev_end (
        output dev_addr, dev_data, dev_sel_n, dev_read_strobe_n, dev_write_strobe_n,
        output dev_burst_seq, dev_bus_oe_n, page, page_oe_n, dev_ack, dev_ack_oe_n,
        output host_bus_grant_n, dev_rdata, dev_rdata_oe_n,
        input host_addr, host_wdata, host_read_strobe_n, host_write_strobe_n,
        input host_burst_seq, host_bus_oe_n, host_bus_req_n, bus_suspend_n, ext_ack,
        input mp_bus_req_n
    );
    modport host_end (
        input dev_addr, dev_data, dev_sel_n, dev_read_strobe_n, dev_write_strobe_n,
        input dev_burst_seq, dev_bus_oe_n, page, page_oe_n, dev_ack, dev_ack_oe_n,
        input host_bus_grant_n, dev_rdata, dev_rdata_oe_n, ext_ack,
        output host_addr, host_wdata, host_read_strobe_n, host_write_strobe_n,
        output host_burst_seq, host_bus_oe_n, host_bus_req_n, bus_suspend_n
    );
endinterface

// ==== rtl/ext_bus_host_end.sv ====
// Far end: host that requests the bus and runs bursts into device memory.
// Assumes the device grants per host_bus_grant_n and inserts waits via ack.
`timescale 1ns/1ps
module ext_bus_host_end (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // User request
    input wire logic req_i,
    input wire logic wr_i,
    input wire logic [ext_bus_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] len_i,
    input wire logic [ext_bus_pkg::DATA_W-1:0] wdata_i,
    input wire logic suspend_i,
    output logic busy_o,
    output logic rvalid_o,
    output logic [ext_bus_pkg::DATA_W-1:0] rdata_o,
    output logic done_o,
    // Bus
    ext_bus_if.host_end bus
);
    import ext_bus_pkg::*;

    typedef enum {H_IDLE, H_REQ, H_XFER, H_REL} host_state_type;
    host_state_type state_q;
    logic [7:0] left_q;
    logic [ADDR_W-1:0] addr_q;
    logic wr_q;
    logic [DATA_W-1:0] wdata_q;
    logic rdv_q;
    logic [DATA_W-1:0] rd_q;
    logic done_q;
    logic first_q;
    logic step;

    // Device ack is sampled only while it drives; otherwise line pulls high
    assign step = (state_q == H_XFER) && (bus.dev_ack_oe_n || bus.dev_ack);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= H_IDLE;
            left_q <= 8'h00;
            addr_q <= '0;
            wr_q <= 1'b0;
            wdata_q <= '0;
            first_q <= 1'b0;
        end else begin
            unique case (state_q)
                H_IDLE: if (req_i) begin
                    state_q <= H_REQ;
                    left_q <= len_i;
                    addr_q <= addr_i;
                    wr_q <= wr_i;
                    wdata_q <= wdata_i;
                    first_q <= 1'b1;
                end
                H_REQ: if (!bus.host_bus_grant_n) begin
                    state_q <= H_XFER;
                end
                H_XFER: if (step) begin
                    first_q <= 1'b0;
                    if (left_q <= 8'h01) begin
                        state_q <= H_REL;
                    end
                    left_q <= left_q - 8'h01;
                    wdata_q <= wdata_q + {{(DATA_W-1){1'b0}}, 1'b1};
                end
                H_REL: state_q <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdv_q <= 1'b0;
            rd_q <= '0;
            done_q <= 1'b0;
        end else begin
            rdv_q <= step && !wr_q;
            if (step && !wr_q) begin
                rd_q <= bus.dev_rdata;
            end
            done_q <= (state_q == H_REL);
        end
    end

    assign busy_o = (state_q != H_IDLE);
    assign rvalid_o = rdv_q;
    assign rdata_o = rd_q;
    assign done_o = done_q;
    assign bus.host_bus_req_n = !(state_q == H_REQ || state_q == H_XFER);
    assign bus.host_bus_oe_n = (state_q != H_XFER);
    // Address stays at the start value; slave counts on its own
    assign bus.host_addr = addr_q;
    assign bus.host_wdata = wdata_q;
    assign bus.host_read_strobe_n = !((state_q == H_XFER) && !wr_q);
    assign bus.host_write_strobe_n = !((state_q == H_XFER) && wr_q);
    // Burst after first access, dropped on the last data cycle
    assign bus.host_burst_seq = (state_q == H_XFER) && !first_q && (left_q > 8'h01);
    // Suspend only for deadlock recovery or DRAM control use
    assign bus.bus_suspend_n = !suspend_i;
endmodule

// ==== rtl/ext_bus_dev_end.sv ====
// Device end: external bus master control, host grant, suspend, burst slave.
// Assumes far parties obey strobes and the shared ack line convention.
`timescale 1ns/1ps
module ext_bus_dev_end (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Configuration
    input wire logic [ext_bus_pkg::PAGE_CODE_W-1:0] page_code_i,
    input wire logic is_master_i,
    // Core access request
    input wire logic acc_req_i,
    input wire logic acc_wr_i,
    input wire logic acc_burst_i,
    input wire logic [ext_bus_pkg::ADDR_W-1:0] acc_addr_i,
    input wire logic [ext_bus_pkg::SEL_W-1:0] acc_sel_i,
    input wire logic [ext_bus_pkg::DATA_W-1:0] acc_wdata_i,
    output logic acc_ready_o,
    output logic acc_done_o,
    output logic [ext_bus_pkg::DATA_W-1:0] acc_rdata_o,
    // Status
    output logic bus_granted_o,
    output logic mp_req_seen_o,
    // Bus
    ext_bus_if.dev_end bus
);
    import ext_bus_pkg::*;

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    bus_state_type arb_q;
    logic float_q;
    logic susp_q;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arb_q <= BUS_OWN;
        end else begin
            unique case (arb_q)
                // Host wins regardless of peer requests
                BUS_OWN: if (!bus.host_bus_req_n && is_master_i) begin
                    arb_q <= BUS_HANDOFF;
                end
                BUS_HANDOFF: arb_q <= BUS_GRANTED;
                BUS_GRANTED: if (bus.host_bus_req_n) begin
                    arb_q <= BUS_OWN;
                end
            endcase
        end
    end
    assign bus.host_bus_grant_n = (arb_q != BUS_GRANTED);
    assign bus_granted_o = (arb_q == BUS_GRANTED);
    assign mp_req_seen_o = !(&bus.mp_bus_req_n);

    // Suspend floats the bus in the following cycle; strobes stop in the same cycle via can_go
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            susp_q <= 1'b0;
        end else begin
            susp_q <= !bus.bus_suspend_n;
        end
    end
    always_comb begin
        float_q = susp_q || (arb_q != BUS_OWN) || !is_master_i;
    end

    // ------------------------------------------------------------
    // Master access
    // ------------------------------------------------------------
    logic act_q;
    logic wr_q;
    logic burst_seq_q;
    logic first_q;
    logic last_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] prev_addr_q;
    logic [SEL_W-1:0] sel_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic done_q;
    logic page_q;
    logic can_go;
    logic xfer;
    logic [4:0] shift;
    logic crossed;

    // Stall while suspended; no completion until released
    assign can_go = !float_q && bus.bus_suspend_n;
    assign xfer = act_q && can_go && bus.ext_ack;
    // Ready on every beat: each burst beat brings its own write data
    assign acc_ready_o = !act_q || xfer;
    assign shift = 5'(PAGE_SHIFT_BASE + {2'b00, page_code_i});
    assign crossed = ((addr_q >> shift) != (prev_addr_q >> shift));

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_q <= 1'b0;
            wr_q <= 1'b0;
            burst_seq_q <= 1'b0;
            first_q <= 1'b0;
            last_q <= 1'b0;
            addr_q <= '0;
            sel_q <= '0;
            wdata_q <= '0;
        end else begin
            if (acc_req_i && acc_ready_o) begin
                act_q <= 1'b1;
                wr_q <= acc_wr_i;
                first_q <= !(act_q && burst_seq_q);
                last_q <= !acc_burst_i;
                burst_seq_q <= acc_burst_i;
                wdata_q <= acc_wdata_i;
                // Burst keeps the first address on the pins
                if (!(act_q && burst_seq_q)) begin
                    addr_q <= acc_addr_i;
                    sel_q <= acc_sel_i;
                end
            end else if (xfer && last_q) begin
                act_q <= 1'b0;
                burst_seq_q <= 1'b0;
            end else if (xfer) begin
                first_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
            rdata_q <= '0;
            prev_addr_q <= '0;
            page_q <= 1'b0;
        end else begin
            done_q <= xfer;
            if (xfer && !wr_q) begin
                rdata_q <= bus.host_wdata;
            end
            if (xfer) begin
                prev_addr_q <= addr_q;
            end
            page_q <= act_q && sel_q[BANK0_SEL] && crossed;
        end
    end
    assign acc_done_o = done_q;
    assign acc_rdata_o = rdata_q;

    assign bus.dev_bus_oe_n = float_q || !act_q;
    assign bus.dev_addr = addr_q;
    assign bus.dev_data = wdata_q;
    assign bus.dev_sel_n = ~sel_q;
    assign bus.dev_read_strobe_n = !(act_q && !wr_q && can_go);
    assign bus.dev_write_strobe_n = !(act_q && wr_q && can_go);
    assign bus.dev_burst_seq = act_q && burst_seq_q && !first_q && !last_q;
    assign bus.page = page_q;
    assign bus.page_oe_n = float_q;

    // ------------------------------------------------------------
    // Slave side: host access to internal memory
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_q [MEM_DEPTH];
    logic [MEM_AW-1:0] sl_addr_q;
    logic sl_act_q;
    logic sl_first_q;
    logic [3:0] wait_q;
    logic sl_strobe;
    logic [DATA_W-1:0] sl_rd_q;
    assign sl_strobe = (arb_q == BUS_GRANTED) && !bus.host_bus_oe_n
        && !(bus.host_read_strobe_n && bus.host_write_strobe_n);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sl_act_q <= 1'b0;
            sl_first_q <= 1'b0;
            sl_addr_q <= '0;
            wait_q <= 4'h0;
        end else if (!sl_strobe) begin
            sl_act_q <= 1'b0;
            sl_first_q <= 1'b0;
            wait_q <= SLAVE_WAIT_CYC;
        end else if (!sl_act_q) begin
            sl_act_q <= 1'b1;
            sl_first_q <= 1'b1;
            sl_addr_q <= bus.host_addr[MEM_AW-1:0];
            wait_q <= SLAVE_WAIT_CYC;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else begin
            // First beat always steps: burst_seq is still low on it
            sl_first_q <= 1'b0;
            if (bus.host_burst_seq || sl_first_q) begin
                sl_addr_q <= sl_addr_q + {{(MEM_AW-1){1'b0}}, 1'b1};
            end
            wait_q <= SLAVE_WAIT_CYC;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sl_act_q && wait_q == 4'h0 && !bus.host_write_strobe_n) begin
            mem_q[sl_addr_q] <= bus.host_wdata;
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sl_rd_q <= '0;
        end else begin
            sl_rd_q <= mem_q[sl_addr_q];
        end
    end
    assign bus.dev_rdata = sl_rd_q;
    assign bus.dev_rdata_oe_n = !(sl_act_q && !bus.host_read_strobe_n);
    // Low while waiting; released when not slave
    assign bus.dev_ack = sl_act_q && (wait_q == 4'h0);
    // Driven from the first strobe cycle so the host never sees a false ready
    assign bus.dev_ack_oe_n = !sl_strobe;
endmodule

// ==== sim/ext_bus_properties.sv ====
// Pin checks between the device end and the host end.
// Assumes the bench wires the interface signals in by name.
`timescale 1ns/1ps
module ext_bus_properties (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Device pins
    input wire logic [ext_bus_pkg::ADDR_W-1:0] dev_addr,
    input wire logic [ext_bus_pkg::SEL_W-1:0] dev_sel_n,
    input wire logic dev_read_strobe_n,
    input wire logic dev_write_strobe_n,
    input wire logic dev_burst_seq,
    input wire logic dev_bus_oe_n,
    input wire logic page,
    input wire logic page_oe_n,
    input wire logic dev_ack,
    input wire logic dev_ack_oe_n,
    input wire logic host_bus_grant_n,
    // Host pins
    input wire logic host_bus_oe_n,
    input wire logic host_bus_req_n,
    input wire logic bus_suspend_n
);
    import ext_bus_pkg::*;
    // ----
    // Properties
    // ----
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence slave_wait_s;
        (!dev_ack_oe_n && !dev_ack) [*3] ##1 (!dev_ack_oe_n && dev_ack);
    endsequence
    sequence beat_start_s;
        $fell(dev_read_strobe_n) || $fell(dev_write_strobe_n);
    endsequence
    a_suspend_float: assert property (!bus_suspend_n |=> dev_bus_oe_n)
        else $error("bus driven after suspend");
    a_float_then_grant: assert property ($fell(host_bus_grant_n) |-> $past(dev_bus_oe_n))
        else $error("grant before float");
    a_granted_floats: assert property (!host_bus_grant_n |-> dev_bus_oe_n)
        else $error("device drives while host owns");
    a_host_owns_bus: assert property (!host_bus_oe_n |-> !host_bus_grant_n)
        else $error("host drives without grant");
    a_grant_held: assert property (!host_bus_grant_n && !host_bus_req_n |=> !host_bus_grant_n)
        else $error("grant dropped early");
    a_grant_release: assert property (host_bus_req_n && !host_bus_grant_n |=> host_bus_grant_n)
        else $error("grant kept after release");
    a_page_bank0: assert property (page && !page_oe_n |-> !$past(dev_sel_n[BANK0_SEL]))
        else $error("page outside bank 0");
    a_slave_wait: assert property ($fell(dev_ack_oe_n) |-> slave_wait_s)
        else $error("wrong slave wait run");
    a_ack_slave_only: assert property (!dev_ack_oe_n |-> !host_bus_grant_n)
        else $error("ack driven when not slave");
    a_burst_first: assert property (beat_start_s |-> !dev_burst_seq)
        else $error("burst flag on first beat");
    a_burst_addr: assert property (dev_burst_seq && !dev_bus_oe_n |-> $stable(dev_addr))
        else $error("address moved in burst");
endmodule

// ==== sim/tb_top.sv ====
// Bench joining the device end and the host end over the bus interface.
// Assumes the bench resolves the shared ack wire and peer requests.
`timescale 1ns/1ps
module tb_top;
    import ext_bus_pkg::*;
    logic ref_clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [PAGE_CODE_W-1:0] page_code = 3'h0;
    logic is_master = 1'h1;
    logic acc_req = 1'h0;
    logic acc_burst = 1'h0;
    logic [ADDR_W-1:0] acc_addr = '0;
    logic [SEL_W-1:0] acc_sel = '0;
    logic [DATA_W-1:0] acc_wdata = '0;
    logic acc_ready, mp_seen, busy, rvalid, acc_done, host_done;
    logic [DATA_W-1:0] rdata;
    logic req = 1'h0;
    logic wr = 1'h0;
    logic suspend = 1'h0;
    logic ack_b = 1'h1;
    logic page_prev = 1'h0;
    logic [5:0] mp = 6'h3f;
    logic [ADDR_W-1:0] addr = '0;
    logic [ADDR_W-1:0] pg, base;
    logic [7:0] len = 8'h0;
    logic [DATA_W-1:0] wdata = '0;
    logic [31:0] seed = 32'h0d13;
    logic [ADDR_W+DATA_W:0] beat_q[$];
    logic [ADDR_W+DATA_W:0] exp_b;
    logic [DATA_W-1:0] rd_q[$];
    int failures = 0;
    int cmp_count = 0;
    int page_hits = 0;
    int beats = 0;
    int dones = 0;
    int host_dones = 0;
    int wait_cnt = 0;
    int h;
    ext_bus_if bif ();
    // Ack takes a random bench value, high about three cycles in four, unless the device drives it
    assign bif.ext_ack = bif.dev_ack_oe_n ? ack_b : bif.dev_ack;
    assign bif.mp_bus_req_n = mp;
    ext_bus_dev_end ext_bus_dev_end_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .page_code_i(page_code), .is_master_i(is_master), .acc_req_i(acc_req), .acc_wr_i(1'h1),
        .acc_burst_i(acc_burst), .acc_addr_i(acc_addr), .acc_sel_i(acc_sel),
        .acc_wdata_i(acc_wdata), .acc_ready_o(acc_ready), .acc_done_o(acc_done), .acc_rdata_o(),
        .bus_granted_o(), .mp_req_seen_o(mp_seen), .bus(bif));
    ext_bus_host_end ext_bus_host_end_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req),
        .wr_i(wr), .addr_i(addr), .len_i(len), .wdata_i(wdata), .suspend_i(suspend),
        .busy_o(busy), .rvalid_o(rvalid), .rdata_o(rdata), .done_o(host_done), .bus(bif));
    ext_bus_properties ext_bus_properties_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .dev_addr(bif.dev_addr), .dev_sel_n(bif.dev_sel_n),
        .dev_read_strobe_n(bif.dev_read_strobe_n), .dev_write_strobe_n(bif.dev_write_strobe_n),
        .dev_burst_seq(bif.dev_burst_seq), .dev_bus_oe_n(bif.dev_bus_oe_n), .page(bif.page),
        .page_oe_n(bif.page_oe_n), .dev_ack(bif.dev_ack), .dev_ack_oe_n(bif.dev_ack_oe_n),
        .host_bus_grant_n(bif.host_bus_grant_n), .host_bus_oe_n(bif.host_bus_oe_n),
        .host_bus_req_n(bif.host_bus_req_n), .bus_suspend_n(bif.bus_suspend_n));
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(string what, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One device write beat; request held until taken
    task automatic dev_beat(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] pin_a,
                            logic [SEL_W-1:0] s, logic more, logic exp_seq);
        int n = 0;
        acc_req = 1'h1;
        acc_burst = more;
        acc_addr = a;
        acc_sel = s;
        acc_wdata = {rnd(), rnd()};
        beat_q.push_back({pin_a, acc_wdata, exp_seq});
        @(negedge ref_clk_i);
        while (!acc_ready && n < 200) begin
            n++;
            @(negedge ref_clk_i);
        end
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic drain();
        int n = 0;
        acc_req = 1'h0;
        while ((beat_q.size() || rd_q.size() || busy !== 1'h0) && n < 400) begin
            n++;
            @(posedge ref_clk_i);
        end
        repeat (3) @(posedge ref_clk_i);
        #1;
        check("left over", beat_q.size() + rd_q.size(), 0);
    endtask
    task automatic host_op(logic w, logic [ADDR_W-1:0] a, logic [7:0] l, logic [DATA_W-1:0] d);
        req = 1'h1;
        wr = w;
        addr = a;
        len = l;
        wdata = d;
        for (int k = 0; k < l; k++)
            if (!w) rd_q.push_back(d + DATA_W'(k));
        @(posedge ref_clk_i);
        #1;
        req = 1'h0;
        drain();
    endtask
    // ----
    // Monitor and stimulus
    // ----
    always @(posedge ref_clk_i) ack_b <= #1 ((rnd() & 32'h3) != 32'h0);
    always @(posedge ref_clk_i) begin
        if (rst_n_i && !bif.dev_bus_oe_n && !bif.dev_write_strobe_n && bif.ext_ack) begin
            beats++;
            exp_b = beat_q.size() ? beat_q.pop_front() : 'x;
            check("addr", bif.dev_addr, exp_b[ADDR_W+DATA_W:DATA_W+1]);
            check("data", bif.dev_data, exp_b[DATA_W:1]);
            check("burst", bif.dev_burst_seq, exp_b[0]);
        end
        if (rvalid) check("rdata", rdata, rd_q.size() ? rd_q.pop_front() : 'x);
        if (acc_done) dones++;
        if (host_done) host_dones++;
        if (bif.page && !bif.page_oe_n && !page_prev) page_hits++;
        page_prev = bif.page && !bif.page_oe_n;
        if (!bif.host_bus_req_n && bif.host_bus_grant_n) wait_cnt++;
        else begin
            if (!bif.host_bus_grant_n && wait_cnt != 0) check("grant delay", wait_cnt, 2);
            wait_cnt = 0;
        end
    end
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    initial begin
        #150us;
        failures++;
        $display("BAD watchdog expected end seen hang");
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'h1;
        for (int c = 0; c < 8; c++) begin
            page_code = 3'(c);
            pg = 32'h1 << (PAGE_SHIFT_BASE + 5'(c));
            base = pg * 4;
            dev_beat(base, base, 4'h1, 1'h0, 1'h0);
            drain();
            h = page_hits;
            dev_beat(base + pg - 1, base + pg - 1, 4'h1, 1'h0, 1'h0);
            dev_beat(base + pg, base + pg, 4'h1, 1'h0, 1'h0);
            dev_beat(base + 3 * pg, base + 3 * pg, 4'h2, 1'h0, 1'h0);
            drain();
            check("page pulses", page_hits - h, 1);
        end
        $display("test page done");
        for (int k = 0; k < 4; k++)
            dev_beat(32'h40 + 32'(k), 32'h40, 4'h2, k < 3, k > 0 && k < 3);
        drain();
        $display("test burst done");
        for (int m = 0; m < 2; m++) begin
            suspend = m == 0;
            is_master = m == 0;
            repeat (2) @(posedge ref_clk_i);
            #1;
            h = beats;
            fork
                begin
                    dev_beat(32'h50, 32'h50, 4'h2, 1'h0, 1'h0);
                    acc_req = 1'h0;
                end
                begin
                    repeat (6) @(posedge ref_clk_i);
                    #1;
                    check("blocked beats", beats - h, 0);
                    suspend = 1'h0;
                    is_master = 1'h1;
                end
            join
            drain();
        end
        $display("test stall done");
        for (int i = 0; i < 4; i++) begin
            mp = 6'(rnd());
            addr = 32'(rnd() % 240);
            len = 8'(rnd() % 8 + 1);
            wdata = {rnd(), rnd()};
            host_op(1'h1, addr, len, wdata);
            check("peer seen", mp_seen, mp != 6'h3f);
            host_op(1'h0, addr, len, wdata);
        end
        check("done pulses", dones, beats);
        check("host done", host_dones, 8);
        $display("test host done");
        give_verdict();
    end
endmodule
